// File: shared/lsq_consts.svh
`ifndef LSQ_CONSTS_SVH
`define LSQ_CONSTS_SVH

// Link clock period, and unit intervals per link (pixel) clock period
`define LSQ_LINK_PERIOD_PS 80000
`define LSQ_UI_PER_PCLK 12
`define LSQ_DEN (`LSQ_UI_PER_PCLK * `LSQ_LINK_PERIOD_PS)
// Cycles for ns + ui unit intervals: least times round up, longest round down
`define LSQ_CYC_UP(ns, ui) (((ns) * 1000 * `LSQ_UI_PER_PCLK + (ui) * `LSQ_LINK_PERIOD_PS + `LSQ_DEN - 1) / `LSQ_DEN)
`define LSQ_CYC_DN(ns, ui) (((ns) * 1000 * `LSQ_UI_PER_PCLK + (ui) * `LSQ_LINK_PERIOD_PS) / `LSQ_DEN)

`define LSQ_T_CLK_PRE_UI 8
`define LSQ_T_CLK_PREP_MIN_NS 38
`define LSQ_T_CLK_PREP_MAX_NS 95
`define LSQ_T_CLK_PREP_ZERO_NS 300
`define LSQ_T_CLK_TRAIL_NS 30
`define LSQ_T_CLK_POST_NS 60
`define LSQ_T_CLK_POST_UI 52
`define LSQ_T_LPX_NS 50
`define LSQ_T_HS_PREP_MIN_NS 40
`define LSQ_T_HS_PREP_MIN_UI 4
`define LSQ_T_HS_PREP_ZERO_NS 145
`define LSQ_T_HS_PREP_ZERO_UI 10
`define LSQ_T_HS_TRAIL_NS 60
`define LSQ_T_HS_TRAIL_UI 4
`define LSQ_T_HS_EXIT_NS 100
`define LSQ_T_WAKEUP_MS 1
`define LSQ_T_CLK_SETTLE_MIN_NS 95
`define LSQ_T_HS_SETTLE_MIN_NS 85
`define LSQ_T_HS_SETTLE_MIN_UI 6
`define LSQ_T_D_TERM_NS 35
`define LSQ_T_D_TERM_UI 4

`define LSQ_CYC_CLK_PRE `LSQ_CYC_UP(0, `LSQ_T_CLK_PRE_UI)
`define LSQ_CYC_CLK_PREP `LSQ_CYC_UP(`LSQ_T_CLK_PREP_MIN_NS, 0)
`define LSQ_CYC_CLK_ZERO (`LSQ_CYC_UP(`LSQ_T_CLK_PREP_ZERO_NS, 0) - `LSQ_CYC_CLK_PREP)
`define LSQ_CYC_CLK_TRAIL `LSQ_CYC_UP(`LSQ_T_CLK_TRAIL_NS, 0)
`define LSQ_CYC_CLK_POST `LSQ_CYC_UP(`LSQ_T_CLK_POST_NS, `LSQ_T_CLK_POST_UI)
`define LSQ_CYC_LPX `LSQ_CYC_UP(`LSQ_T_LPX_NS, 0)
`define LSQ_CYC_HS_PREP `LSQ_CYC_UP(`LSQ_T_HS_PREP_MIN_NS, `LSQ_T_HS_PREP_MIN_UI)
`define LSQ_CYC_HS_ZERO (`LSQ_CYC_UP(`LSQ_T_HS_PREP_ZERO_NS, `LSQ_T_HS_PREP_ZERO_UI) - `LSQ_CYC_HS_PREP)
`define LSQ_CYC_HS_TRAIL `LSQ_CYC_UP(`LSQ_T_HS_TRAIL_NS, `LSQ_T_HS_TRAIL_UI)
`define LSQ_CYC_HS_EXIT `LSQ_CYC_UP(`LSQ_T_HS_EXIT_NS, 0)
`define LSQ_CYC_WAKEUP ((`LSQ_T_WAKEUP_MS * 1000000000 + `LSQ_LINK_PERIOD_PS - 1) / `LSQ_LINK_PERIOD_PS)
`define LSQ_CYC_CLK_SETTLE `LSQ_CYC_UP(`LSQ_T_CLK_SETTLE_MIN_NS, 0)
`define LSQ_CYC_HS_SETTLE `LSQ_CYC_UP(`LSQ_T_HS_SETTLE_MIN_NS, `LSQ_T_HS_SETTLE_MIN_UI)
`define LSQ_CYC_D_TERM `LSQ_CYC_UP(`LSQ_T_D_TERM_NS, `LSQ_T_D_TERM_UI)

`define LSQ_LP11 2'h3
`define LSQ_LP10 2'h2
`define LSQ_LP01 2'h1
`define LSQ_LP00 2'h0
`define LSQ_SYNC_BYTE 8'hb8
`define LSQ_FIFO_DEPTH 32
`define LSQ_WORD_W 16

`endif

// File: shared/lsq_pkg.sv
package lsq_pkg;

  typedef enum logic [3:0] {
    TX_STOP, TX_CLK_LP01, TX_CLK_LP00, TX_CLK_ZERO, TX_CLK_PRE, TX_D_LP01, TX_D_LP00, TX_D_ZERO,
    TX_D_SYNC, TX_PAYLOAD, TX_D_TRAIL, TX_CLK_POST, TX_CLK_TRAIL, TX_EXIT, TX_ULPS, TX_WAKE
  } lsq_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE, RX_LP01, RX_TERM, RX_SETTLE, RX_HUNT, RX_RECV, RX_EOT
  } lsq_rx_state_t;

  typedef struct packed {
    logic [1:0] clk_lp;
    logic       clk_hs_en;
    logic       clk_hs;
    logic [1:0] d_lp;
    logic       d_hs_en;
    logic [7:0] d0;
    logic [7:0] d1;
  } lsq_lanes_t;

endpackage : lsq_pkg

// File: shared/lsq_lane_if.sv
`timescale 1ns/1ps
interface lsq_lane_if (
  input wire logic link_clk
);
  logic [1:0] clk_lane_lp;
  logic       clk_lane_hs_en;
  logic       clk_lane_hs;
  logic [1:0] data_lane_lp;
  logic       data_lane_hs_en;
  logic [7:0] data_lane_zero_pair;
  logic [7:0] data_lane_one_pair;
  logic       clk_lane_term_en;
  logic       data_lane_term_en;

  modport tx (
    input  link_clk,
    output clk_lane_lp,
    output clk_lane_hs_en,
    output clk_lane_hs,
    output data_lane_lp,
    output data_lane_hs_en,
    output data_lane_zero_pair,
    output data_lane_one_pair,
    input  clk_lane_term_en,
    input  data_lane_term_en
  );

  modport rx (
    input  link_clk,
    input  clk_lane_lp,
    input  clk_lane_hs_en,
    input  clk_lane_hs,
    input  data_lane_lp,
    input  data_lane_hs_en,
    input  data_lane_zero_pair,
    input  data_lane_one_pair,
    output clk_lane_term_en,
    output data_lane_term_en
  );
endinterface : lsq_lane_if

// File: rtl/lsq_tx.sv
`timescale 1ns/1ps
`include "lsq_consts.svh"

module lsq_fifo #(
  parameter int WIDTH = `LSQ_WORD_W,
  parameter int DEPTH = `LSQ_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lsq_fifo_st_t;

  lsq_fifo_st_t     q;
  lsq_fifo_st_t     next_q;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;

  // Extra pointer bit tells full from empty
  assign in_ready  = !((q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]));
  assign out_valid = q.wp != q.rp;
  assign out_data  = mem[q.rp[AW-1:0]];
  assign push      = ce && in_valid && in_ready;

  always_comb begin
    next_q = q;
    if (push) begin
      next_q.wp = q.wp + 1'b1;
    end
    if (ce && out_valid && out_ready) begin
      next_q.rp = q.rp + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[q.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : lsq_fifo

module lsq_tx #(
  parameter int WAKE_CYC = `LSQ_CYC_WAKEUP
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  lsq_lane_if.tx           lanes,
  input  wire logic        word_valid,
  output logic             word_ready,
  input  wire logic [15:0] word_data,
  input  wire logic        ulps_req,
  output logic             link_busy
);
  typedef struct packed {
    logic        req;
    logic [15:0] data;
    logic        ack_m;
    logic        ack_s;
    logic        busy_m;
    logic        busy_s;
  } lsq_txu_t;

  typedef struct packed {
    lsq_pkg::lsq_tx_state_t st;
    logic [15:0]            cnt;
    logic                   tog;
    logic                   busy;
    logic                   req_m;
    logic                   req_s;
    logic                   seen;
    logic                   ulps_m;
    logic                   ulps_s;
    logic                   ce_m;
    logic                   ce_s;
    lsq_pkg::lsq_lanes_t    lo;
  } lsq_txl_t;

  lsq_txu_t    u;
  lsq_txu_t    next_u;
  lsq_txl_t    q;
  lsq_txl_t    next_q;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [15:0] f_out_data;
  logic        push;
  logic        pop;

  function automatic lsq_txl_t step(input lsq_txl_t s, input lsq_pkg::lsq_tx_state_t st, input int cyc);
    s.st  = st;
    s.cnt = 16'(cyc - 1);
    return s;
  endfunction : step

  // Lane levels per state; the link clock carries 12 UI per cycle so UI terms fold into cycles
  function automatic lsq_pkg::lsq_lanes_t lanes_of(input lsq_pkg::lsq_tx_state_t st, input logic tog,
                                                   input logic [15:0] w);
    lsq_pkg::lsq_lanes_t l;
    l = '{clk_lp: `LSQ_LP11, clk_hs_en: 1'b0, clk_hs: 1'b0, d_lp: `LSQ_LP11, d_hs_en: 1'b0,
          d0: 8'h00, d1: 8'h00};
    if (st inside {[lsq_pkg::TX_CLK_LP00 : lsq_pkg::TX_CLK_TRAIL], lsq_pkg::TX_ULPS}) begin
      l.clk_lp = `LSQ_LP00;
    end
    if (st inside {[lsq_pkg::TX_D_LP00 : lsq_pkg::TX_D_TRAIL], lsq_pkg::TX_ULPS}) begin
      l.d_lp = `LSQ_LP00;
    end
    if (st == lsq_pkg::TX_CLK_LP01) begin
      l.clk_lp = `LSQ_LP01;
    end
    if (st == lsq_pkg::TX_D_LP01) begin
      l.d_lp = `LSQ_LP01;
    end
    if (st == lsq_pkg::TX_WAKE) begin
      l.clk_lp = `LSQ_LP10;
      l.d_lp   = `LSQ_LP10;
    end
    l.clk_hs_en = st inside {[lsq_pkg::TX_CLK_ZERO : lsq_pkg::TX_CLK_TRAIL]};
    l.clk_hs    = tog && (st inside {[lsq_pkg::TX_CLK_PRE : lsq_pkg::TX_CLK_POST]});
    l.d_hs_en   = st inside {[lsq_pkg::TX_D_ZERO : lsq_pkg::TX_D_TRAIL]};
    if (st == lsq_pkg::TX_D_SYNC) begin
      l.d0 = `LSQ_SYNC_BYTE;
      l.d1 = `LSQ_SYNC_BYTE;
    end
    if (st == lsq_pkg::TX_PAYLOAD) begin
      l.d0 = w[7:0];
      l.d1 = w[15:8];
    end
    return l;
  endfunction : lanes_of

  // User side: one word in flight across the toggle handshake
  assign word_ready = (u.req == u.ack_s);
  assign link_busy  = u.busy_s;

  always_comb begin
    next_u        = u;
    next_u.ack_m  = q.seen;
    next_u.ack_s  = u.ack_m;
    next_u.busy_m = q.busy;
    next_u.busy_s = u.busy_m;
    if (ce && word_valid && word_ready) begin
      next_u.req  = ~u.req;
      next_u.data = word_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      u <= '0;
    end else begin
      u <= next_u;
    end
  end

  // The FIFO lives on the link clock so a burst drains it without crossings
  lsq_fifo #(
    .WIDTH (`LSQ_WORD_W),
    .DEPTH (`LSQ_FIFO_DEPTH)
  ) fifo_i (
    .clk       (lanes.link_clk),
    .rst       (rst),
    .ce        (q.ce_s),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (u.data),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  assign push = q.req_s != q.seen;
  assign pop  = (q.st == lsq_pkg::TX_PAYLOAD) && f_out_valid;

  always_comb begin
    next_q        = q;
    next_q.req_m  = u.req;
    next_q.req_s  = q.req_m;
    next_q.ulps_m = ulps_req;
    next_q.ulps_s = q.ulps_m;
    next_q.ce_m   = ce;
    next_q.ce_s   = q.ce_m;
    if (q.ce_s) begin
      next_q.tog = ~q.tog;
      if (push && f_in_ready) begin
        next_q.seen = q.req_s;
      end
      if (q.cnt != 16'h0000) begin
        next_q.cnt = q.cnt - 16'h0001;
      end else begin
        unique case (q.st)
          lsq_pkg::TX_STOP: begin
            if (q.ulps_s) begin
              next_q = step(next_q, lsq_pkg::TX_ULPS, 1);
            end else if (f_out_valid) begin
              next_q = step(next_q, lsq_pkg::TX_CLK_LP01, `LSQ_CYC_LPX);
            end
          end
          lsq_pkg::TX_CLK_LP01:  next_q = step(next_q, lsq_pkg::TX_CLK_LP00, `LSQ_CYC_CLK_PREP);
          lsq_pkg::TX_CLK_LP00:  next_q = step(next_q, lsq_pkg::TX_CLK_ZERO, `LSQ_CYC_CLK_ZERO);
          lsq_pkg::TX_CLK_ZERO: begin
            // Clock starts on a one so the pre window always carries an edge
            next_q     = step(next_q, lsq_pkg::TX_CLK_PRE, `LSQ_CYC_CLK_PRE);
            next_q.tog = 1'b1;
          end
          lsq_pkg::TX_CLK_PRE:   next_q = step(next_q, lsq_pkg::TX_D_LP01, `LSQ_CYC_LPX);
          lsq_pkg::TX_D_LP01:    next_q = step(next_q, lsq_pkg::TX_D_LP00, `LSQ_CYC_HS_PREP);
          lsq_pkg::TX_D_LP00:    next_q = step(next_q, lsq_pkg::TX_D_ZERO, `LSQ_CYC_HS_ZERO);
          lsq_pkg::TX_D_ZERO:    next_q = step(next_q, lsq_pkg::TX_D_SYNC, 1);
          lsq_pkg::TX_D_SYNC:    next_q = step(next_q, lsq_pkg::TX_PAYLOAD, 1);
          lsq_pkg::TX_PAYLOAD: begin
            // The burst ends as soon as the FIFO runs dry
            // The dry cycle already sends the first zero trail byte
            if (!f_out_valid) begin
              next_q = step(next_q, lsq_pkg::TX_D_TRAIL, `LSQ_CYC_HS_TRAIL - 1);
            end
          end
          lsq_pkg::TX_D_TRAIL:   next_q = step(next_q, lsq_pkg::TX_CLK_POST, `LSQ_CYC_CLK_POST);
          lsq_pkg::TX_CLK_POST:  next_q = step(next_q, lsq_pkg::TX_CLK_TRAIL, `LSQ_CYC_CLK_TRAIL);
          lsq_pkg::TX_CLK_TRAIL: next_q = step(next_q, lsq_pkg::TX_EXIT, `LSQ_CYC_HS_EXIT);
          lsq_pkg::TX_EXIT:      next_q = step(next_q, lsq_pkg::TX_STOP, 1);
          lsq_pkg::TX_ULPS: begin
            if (!q.ulps_s) begin
              next_q = step(next_q, lsq_pkg::TX_WAKE, WAKE_CYC);
            end
          end
          lsq_pkg::TX_WAKE:      next_q = step(next_q, lsq_pkg::TX_EXIT, `LSQ_CYC_HS_EXIT);
        endcase
      end
      next_q.busy = next_q.st != lsq_pkg::TX_STOP;
      next_q.lo   = lanes_of(q.st, q.tog, f_out_valid ? f_out_data : 16'h0000);
    end
  end

  always_ff @(posedge lanes.link_clk or posedge rst) begin
    if (rst) begin
      q    <= '0;
      q.lo <= '{clk_lp: `LSQ_LP11, clk_hs_en: 1'b0, clk_hs: 1'b0, d_lp: `LSQ_LP11, d_hs_en: 1'b0,
               d0: 8'h00, d1: 8'h00};
    end else begin
      q <= next_q;
    end
  end

  assign lanes.clk_lane_lp         = q.lo.clk_lp;
  assign lanes.clk_lane_hs_en      = q.lo.clk_hs_en;
  assign lanes.clk_lane_hs         = q.lo.clk_hs;
  assign lanes.data_lane_lp        = q.lo.d_lp;
  assign lanes.data_lane_hs_en     = q.lo.d_hs_en;
  assign lanes.data_lane_zero_pair = q.lo.d0;
  assign lanes.data_lane_one_pair  = q.lo.d1;
endmodule : lsq_tx

// File: rtl/lsq_rx.sv
`timescale 1ns/1ps
`include "lsq_consts.svh"

module lsq_rx (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  lsq_lane_if.rx           lanes,
  output logic             word_valid,
  input  wire logic        word_ready,
  output logic [15:0]      word_data,
  output logic             rx_overflow,
  output logic             clk_locked
);
  localparam int NP = `LSQ_CYC_HS_TRAIL;

  typedef struct packed {
    lsq_pkg::lsq_rx_state_t st;
    logic [3:0]             cnt;
    logic [3:0]             ccnt;
    logic                   clk_term;
    logic                   clk_ok;
    logic                   d_term;
    logic [NP-1:0][15:0]    pend;
    logic [NP-1:0]          pv;
    logic                   ovf;
    logic                   req;
    logic [15:0]            word;
    logic                   ack_m;
    logic                   ack_s;
    logic                   ce_m;
    logic                   ce_s;
  } lsq_rxl_t;

  typedef struct packed {
    logic req_m;
    logic req_s;
    logic seen;
    logic ovf_m;
    logic ovf_s;
    logic lock_m;
    logic lock_s;
  } lsq_rxu_t;

  lsq_rxl_t    q;
  lsq_rxl_t    next_q;
  lsq_rxu_t    u;
  lsq_rxu_t    next_u;
  logic        push;
  logic        pop;
  logic        f_in_ready;
  logic        f_out_valid;
  logic [15:0] f_out_data;
  logic        clk_lp00;

  assign clk_lp00 = (lanes.clk_lane_lp == `LSQ_LP00) && !lanes.clk_lane_hs_en;

  // Combinational term so the enable follows LP-00 within the same cycle
  assign lanes.clk_lane_term_en  = q.clk_term || clk_lp00;
  assign lanes.data_lane_term_en = q.d_term;

  // Trail bytes are held back so they never reach the FIFO
  assign push = (q.st == lsq_pkg::RX_RECV) && lanes.data_lane_hs_en && q.pv[NP-1];
  assign pop  = f_out_valid && (q.req == q.ack_s);

  lsq_fifo #(
    .WIDTH (`LSQ_WORD_W),
    .DEPTH (`LSQ_FIFO_DEPTH)
  ) fifo_i (
    .clk       (lanes.link_clk),
    .rst       (rst),
    .ce        (q.ce_s),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   (q.pend[NP-1]),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  always_comb begin
    next_q       = q;
    next_q.ack_m = u.seen;
    next_q.ack_s = q.ack_m;
    next_q.ce_m  = ce;
    next_q.ce_s  = q.ce_m;
    if (q.ce_s) begin
      if (pop) begin
        next_q.word = f_out_data;
        next_q.req  = ~q.req;
      end
      if (push && !f_in_ready) begin
        next_q.ovf = 1'b1;
      end
      if (lanes.clk_lane_lp == `LSQ_LP11 && !lanes.clk_lane_hs_en) begin
        next_q.clk_term = 1'b0;
        next_q.clk_ok   = 1'b0;
        next_q.ccnt     = 4'h0;
      end else if (clk_lp00 && !q.clk_term) begin
        next_q.clk_term = 1'b1;
        next_q.ccnt     = 4'(`LSQ_CYC_CLK_SETTLE);
      end else if (q.ccnt != 4'h0) begin
        next_q.ccnt = q.ccnt - 4'h1;
      end else if (lanes.clk_lane_hs_en) begin
        next_q.clk_ok = 1'b1;
      end
      if (q.cnt != 4'h0) begin
        next_q.cnt = q.cnt - 4'h1;
      end else begin
        unique case (q.st)
          lsq_pkg::RX_IDLE: begin
            if (lanes.data_lane_lp == `LSQ_LP01) begin
              next_q.st = lsq_pkg::RX_LP01;
            end
          end
          lsq_pkg::RX_LP01: begin
            if (lanes.data_lane_lp == `LSQ_LP00) begin
              next_q.st  = lsq_pkg::RX_TERM;
              next_q.cnt = 4'(`LSQ_CYC_D_TERM - 1);
            end else if (lanes.data_lane_lp == `LSQ_LP11) begin
              next_q.st = lsq_pkg::RX_IDLE;
            end
          end
          lsq_pkg::RX_TERM: begin
            next_q.d_term = 1'b1;
            next_q.st     = lsq_pkg::RX_SETTLE;
            next_q.cnt    = 4'(`LSQ_CYC_HS_SETTLE - `LSQ_CYC_D_TERM - 1);
          end
          lsq_pkg::RX_SETTLE: next_q.st = lsq_pkg::RX_HUNT;
          lsq_pkg::RX_HUNT: begin
            if (!lanes.data_lane_hs_en) begin
              next_q.st = lsq_pkg::RX_EOT;
            end else if (q.clk_ok && lanes.data_lane_zero_pair == `LSQ_SYNC_BYTE &&
                         lanes.data_lane_one_pair == `LSQ_SYNC_BYTE) begin
              next_q.st = lsq_pkg::RX_RECV;
              next_q.pv = '0;
            end
          end
          lsq_pkg::RX_RECV: begin
            if (lanes.data_lane_hs_en) begin
              next_q.pend = {q.pend[NP-2:0], lanes.data_lane_one_pair, lanes.data_lane_zero_pair};
              next_q.pv   = {q.pv[NP-2:0], 1'b1};
            end else begin
              next_q.st = lsq_pkg::RX_EOT;
            end
          end
          lsq_pkg::RX_EOT: begin
            // Any LP pulse before LP-11 settles is a glitch
            next_q.d_term = 1'b0;
            next_q.pv     = '0;
            if (lanes.data_lane_lp == `LSQ_LP11) begin
              next_q.st = lsq_pkg::RX_IDLE;
            end
          end
          default: next_q.st = lsq_pkg::RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge lanes.link_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign word_valid  = u.req_s != u.seen;
  assign word_data   = q.word;
  assign rx_overflow = u.ovf_s;
  assign clk_locked  = u.lock_s;

  always_comb begin
    next_u        = u;
    next_u.req_m  = q.req;
    next_u.req_s  = u.req_m;
    next_u.ovf_m  = q.ovf;
    next_u.ovf_s  = u.ovf_m;
    next_u.lock_m = q.clk_ok;
    next_u.lock_s = u.lock_m;
    if (ce && word_valid && word_ready) begin
      next_u.seen = u.req_s;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      u <= '0;
    end else begin
      u <= next_u;
    end
  end
endmodule : lsq_rx

// File: testbench/lsq_lane_checker.sv
`timescale 1ns/1ps
`include "lsq_consts.svh"

module lsq_lane_checker #(
  parameter int WAKE_CYC = 20
) (
  input wire logic       link_clk,
  input wire logic       rst,
  input wire logic [1:0] clk_lane_lp,
  input wire logic       clk_lane_hs_en,
  input wire logic       clk_lane_hs,
  input wire logic [1:0] data_lane_lp,
  input wire logic       data_lane_hs_en,
  input wire logic [7:0] data_lane_zero_pair,
  input wire logic [7:0] data_lane_one_pair,
  input wire logic       clk_lane_term_en,
  input wire logic       data_lane_term_en
);
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (rst);

  // Length of the current wake-up mark, in link cycles
  int unsigned mark_cnt;
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      mark_cnt <= 0;
    end else if (data_lane_lp == `LSQ_LP10) begin
      mark_cnt <= mark_cnt + 1;
    end else begin
      mark_cnt <= 0;
    end
  end

  sequence s_d_request;
    data_lane_lp == `LSQ_LP01 && $past(data_lane_lp) == `LSQ_LP11;
  endsequence
  sequence s_d_prepare;
    data_lane_lp == `LSQ_LP00 && !data_lane_hs_en;
  endsequence
  sequence s_d_zero;
    data_lane_hs_en && data_lane_zero_pair == 8'h00 && data_lane_one_pair == 8'h00;
  endsequence
  sequence s_d_sync;
    data_lane_zero_pair == `LSQ_SYNC_BYTE && data_lane_one_pair == `LSQ_SYNC_BYTE;
  endsequence
  sequence s_c_request;
    clk_lane_lp == `LSQ_LP01 && $past(clk_lane_lp) == `LSQ_LP11;
  endsequence
  sequence s_c_zero;
    clk_lane_hs_en && !clk_lane_hs;
  endsequence

  property p_d_entry;
    s_d_request |=> s_d_prepare ##1 s_d_zero [*2] ##1 s_d_sync;
  endproperty
  a_d_entry: assert property (p_d_entry) else $error("data lane entry steps wrong");

  property p_c_entry;
    s_c_request |=> (clk_lane_lp == `LSQ_LP00 && !clk_lane_hs_en) ##1 s_c_zero [*3] ##1 clk_lane_hs_en;
  endproperty
  a_c_entry: assert property (p_c_entry) else $error("clock lane entry steps wrong");

  property p_clk_pre;
    s_d_request |-> clk_lane_hs_en && $past(clk_lane_hs_en) && $past(clk_lane_hs) != $past(clk_lane_hs, 2);
  endproperty
  a_clk_pre: assert property (p_clk_pre) else $error("clock not running before data entry");

  property p_d_trail;
    $fell(data_lane_hs_en) |-> data_lane_lp == `LSQ_LP11 && $past(data_lane_hs_en, 2)
      && $past(data_lane_zero_pair) == 8'h00 && $past(data_lane_one_pair) == 8'h00
      && $past(data_lane_zero_pair, 2) == 8'h00 && $past(data_lane_one_pair, 2) == 8'h00;
  endproperty
  a_d_trail: assert property (p_d_trail) else $error("data trail wrong");

  property p_d_exit;
    $fell(data_lane_hs_en) |-> (data_lane_lp == `LSQ_LP11 && !data_lane_hs_en) [*8];
  endproperty
  a_d_exit: assert property (p_d_exit) else $error("stop state cut short");

  property p_c_trail;
    $fell(data_lane_hs_en) |-> clk_lane_hs_en [*6] ##1 s_c_zero ##1 !clk_lane_hs_en;
  endproperty
  a_c_trail: assert property (p_c_trail) else $error("clock trail wrong");

  property p_c_term;
    (clk_lane_lp == `LSQ_LP00 && $past(clk_lane_lp) == `LSQ_LP01) |-> clk_lane_term_en;
  endproperty
  a_c_term: assert property (p_c_term) else $error("clock termination late");

  property p_d_term;
    (data_lane_lp == `LSQ_LP00 && $past(data_lane_lp) == `LSQ_LP01) |-> !data_lane_term_en ##[1:3] data_lane_term_en;
  endproperty
  a_d_term: assert property (p_d_term) else $error("data termination timing wrong");

  property p_wake;
    ($past(data_lane_lp) == `LSQ_LP10 && data_lane_lp != `LSQ_LP10) |-> mark_cnt >= WAKE_CYC
      && data_lane_lp == `LSQ_LP11;
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up mark too short");
endmodule : lsq_lane_checker

// File: testbench/test_csi2_dphy_tx_lane_sequencer.sv
`timescale 1ns/1ps
`include "lsq_consts.svh"

module test_csi2_dphy_tx_lane_sequencer;
  localparam int WAKE = 20;
  logic        clk;
  logic        link_clk;
  logic        rst;
  logic        ce;
  logic        tx_valid;
  logic        tx_ready;
  logic [15:0] tx_data;
  logic        ulps_req;
  logic        link_busy;
  logic        rx_valid;
  logic        rx_ready = 1'b1;
  logic        lock_seen = 1'b0;
  logic [15:0] rx_data;
  logic        rx_overflow;
  logic        clk_locked;
  logic [15:0] expect_q[$];
  logic [15:0] edge_w[4] = '{16'h0000, 16'hffff, 16'hb8b8, 16'h00ff};
  logic        prev_hs;
  int          zero_run;
  int          n_mismatch;
  int          tests_run;

  lsq_lane_if lsq_lane_if_inst (.link_clk(link_clk));
  lsq_tx #(.WAKE_CYC(WAKE)) lsq_tx_inst (.clk(clk), .rst(rst), .ce(ce), .lanes(lsq_lane_if_inst),
    .word_valid(tx_valid), .word_ready(tx_ready), .word_data(tx_data), .ulps_req(ulps_req), .link_busy(link_busy));
  lsq_rx lsq_rx_inst (.clk(clk), .rst(rst), .ce(ce), .lanes(lsq_lane_if_inst), .word_valid(rx_valid),
    .word_ready(rx_ready), .word_data(rx_data), .rx_overflow(rx_overflow), .clk_locked(clk_locked));
  lsq_lane_checker #(.WAKE_CYC(WAKE)) lsq_lane_checker_inst (.link_clk(link_clk), .rst(rst),
    .clk_lane_lp(lsq_lane_if_inst.clk_lane_lp), .clk_lane_hs_en(lsq_lane_if_inst.clk_lane_hs_en),
    .clk_lane_hs(lsq_lane_if_inst.clk_lane_hs), .data_lane_lp(lsq_lane_if_inst.data_lane_lp),
    .data_lane_hs_en(lsq_lane_if_inst.data_lane_hs_en), .data_lane_zero_pair(lsq_lane_if_inst.data_lane_zero_pair),
    .data_lane_one_pair(lsq_lane_if_inst.data_lane_one_pair),
    .clk_lane_term_en(lsq_lane_if_inst.clk_lane_term_en), .data_lane_term_en(lsq_lane_if_inst.data_lane_term_en));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Odd offset keeps the link clock out of phase with clk
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
    tests_run++;
    if (got !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  // Ready is sampled on the falling edge, so the word is taken at the next rising edge
  task automatic send(input logic [15:0] w);
    int i;
    for (i = 0; i < 200 && tx_ready !== 1'b1; i++) @(negedge clk);
    if (i == 200) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: word never accepted", $time);
    end
    tx_valid = 1'b1;
    tx_data  = w;
    expect_q.push_back(w);
    @(negedge clk);
    tx_valid = 1'b0;
    @(negedge clk);
  endtask : send

  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && (expect_q.size() != 0 || link_busy !== 1'b0); i++) @(negedge clk);
    if (i == 2000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: link never went idle", $time);
    end
    repeat (4) @(negedge clk);
  endtask : wait_idle

  // Reader stalls at random; the receiver must not lose words meanwhile
  always @(negedge clk) rx_ready = (($urandom() % 4) != 0);

  always @(posedge clk) begin
    if (clk_locked === 1'b1) lock_seen = 1'b1;
    if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
      if (expect_q.size() == 0) begin
        check(rx_data, 16'hxxxx, "unexpected word");
      end else begin
        check(rx_data, expect_q.pop_front(), "word");
      end
    end
  end

  // Wire watch: HS-0 cycles on lane zero ahead of the sync byte on both lanes
  always @(posedge link_clk) begin
    if (zero_run >= 0 && lsq_lane_if_inst.data_lane_zero_pair !== 8'h00) begin
      check({lsq_lane_if_inst.data_lane_one_pair, lsq_lane_if_inst.data_lane_zero_pair}, 16'hb8b8, "sync");
      check(16'(zero_run), 16'h0002, "zero cycles");
      zero_run = -1;
    end else if (zero_run >= 0) begin
      zero_run++;
    end
    if (lsq_lane_if_inst.data_lane_hs_en === 1'b1 && prev_hs !== 1'b1) zero_run = 1;
    prev_hs = lsq_lane_if_inst.data_lane_hs_en;
  end

  initial begin
    #2_000_000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  initial begin
    void'($urandom(58089));
    n_mismatch = 0;
    tests_run  = 0;
    rst        = 1'b1;
    ce         = 1'b1;
    tx_valid   = 1'b0;
    tx_data    = 16'h0000;
    ulps_req   = 1'b0;
    prev_hs    = 1'b0;
    zero_run   = -1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    foreach (edge_w[k]) begin
      send(edge_w[k]);
      wait_idle();
    end
    repeat (40) send(16'($urandom));
    wait_idle();
    ulps_req = 1'b1;
    repeat (20) @(negedge clk);
    check({14'h0000, lsq_lane_if_inst.data_lane_lp}, 16'h0000, "ulps level");
    check({15'h0000, link_busy}, 16'h0001, "busy in ulps");
    ulps_req = 1'b0;
    repeat (10) @(negedge clk);
    check({14'h0000, lsq_lane_if_inst.data_lane_lp}, 16'h0002, "wake mark");
    wait_idle();
    send(16'ha5c3);
    wait_idle();
    rst = 1'b1;
    repeat (4) @(negedge clk);
    check({14'h0000, lsq_lane_if_inst.data_lane_lp}, 16'h0003, "reset level");
    rst = 1'b0;
    repeat (10) @(negedge clk);
    send(16'h1234);
    wait_idle();
    check({15'h0000, rx_overflow}, 16'h0000, "overflow");
    check({15'h0000, clk_locked}, 16'h0000, "lock at idle");
    check({15'h0000, lock_seen}, 16'h0001, "lock during burst");
    conclude();
  end
endmodule : test_csi2_dphy_tx_lane_sequencer
